// *** test/periodic_modulus_counter_test.sv ***
// Purpose: Register-level bench for the periodic modulus counter
// Assumes: APB answers after one wait state; source pins driven slowly
// Notes: Each source edge is 4 cycles high, at least 4 low (5 between pulses), so the count settles per pulse
`timescale 1ns/1ps
`default_nettype none
module periodic_modulus_counter_test;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] src;
   logic irq;
   logic [31:0] r;
   logic e;
   int num_errors;
   int num_checks;
   int i;
   pmc_top pmc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .low_power_osc(src[0]),
      .external_ref_clock(src[1]), .internal_ref_clock(src[2]), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd_data, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Read right at the edge, before its updates land: what the edge samples
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         finish_test();
      end else begin
         rd_data = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask
   task automatic chk_irq(input logic exp);
      repeat (2) @(negedge pclk);
      check({31'h0, irq}, {31'h0, exp});
   endtask
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge pclk);
         src[idx] <= 1'b1;
         repeat (4) @(posedge pclk);
         src[idx] <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      src = 3'h0;
      num_errors = 0;
      num_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h00);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      rd(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'h00);
      chk_irq(1'b0);
      pulse(0, 3);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      $display("test reset done");
      wr(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'h02);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h08);
      for (i = 1; i <= 4; i++) begin
         pulse(0, 1);
         rd(pmc_pkg::PMC_OFF_COUNT_VALUE, i % 3);
         rd(pmc_pkg::PMC_OFF_STATUS_CONTROL, (i >= 3) ? 32'h88 : 32'h08);
      end
      $display("test wrap done");
      chk_irq(1'b0);
      wr(pmc_pkg::PMC_OFF_INT_MASK, 32'h01);
      chk_irq(1'b1);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h18);
      rd(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h98);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h98);
      rd(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h18);
      chk_irq(1'b0);
      $display("test irq done");
      wr(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h55);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h01);
      wr(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'hff);
      rd(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'hff);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      wr(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'h00);
      for (i = 0; i < 2; i++) begin
         pulse(0, 1);
         rd(pmc_pkg::PMC_OFF_INT_STATUS, 32'h01);
         chk_irq(1'b1);
         wr(pmc_pkg::PMC_OFF_INT_STATUS, 32'h01);
         rd(pmc_pkg::PMC_OFF_INT_STATUS, 32'h00);
      end
      $display("test limit done");
      wr(pmc_pkg::PMC_OFF_COMPARE_LIMIT, 32'h05);
      pulse(0, 2);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h02);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h58);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(0, 2);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(2, 2);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h02);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h78);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(2, 1);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      $display("test source done");
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h11);
      pulse(0, 7);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(0, 1);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h01);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h19);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(0, 2);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h01);
      wr(pmc_pkg::PMC_OFF_STATUS_CONTROL, 32'h38);
      pulse(1, 999);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h00);
      pulse(1, 1);
      rd(pmc_pkg::PMC_OFF_COUNT_VALUE, 32'h01);
      $display("test divide done");
      apb(1'b0, 8'h20, 32'h0, r, e);
      check(r, 32'h0);
      check({31'h0, e}, 32'h1);
      $display("test unmapped done");
      finish_test();
   end
endmodule // periodic_modulus_counter_test
`default_nettype wire

// *** test/pmc_chk_sva.sv ***
// Purpose: Port-level assertions for the periodic modulus counter
// Assumes: Source pins change no faster than pclk/4
// Notes: Bound into pmc_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pmc_chk #(
   parameter int unsigned ADDR_W = pmc_pkg::PMC_ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic low_power_osc,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   input wire logic irq
);
   logic [3:0] quiet_ff;
   logic wr_done;
   logic mapped;
   logic at_status;
   assign wr_done = psel && penable && pready && pwrite;
   assign at_status = paddr == pmc_pkg::PMC_OFF_STATUS_CONTROL;
   assign mapped = at_status || paddr == pmc_pkg::PMC_OFF_COUNT_VALUE ||
      paddr == pmc_pkg::PMC_OFF_COMPARE_LIMIT || paddr == pmc_pkg::PMC_OFF_INT_STATUS ||
      paddr == pmc_pkg::PMC_OFF_INT_MASK;
   // Idle source pins long enough that no tick can still be in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_ff <= 4'h0;
      end else if (low_power_osc || external_ref_clock || internal_ref_clock) begin
         quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hf) begin
         quiet_ff <= quiet_ff + 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_one_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_reset_idle: assert property ($rose(presetn) |-> !irq && !pready && prdata == 32'h0)
      else $error("outputs not idle after reset");
   chk_upper_zero: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   chk_err_unmapped: assert property ((psel && penable && pready) |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   chk_flag_clear: assert property ((wr_done && pstrb[0] && quiet_ff >= 4'h8 &&
      ((at_status && pwdata[7]) || (paddr == pmc_pkg::PMC_OFF_INT_STATUS && pwdata[0])))
      |-> ##[1:2] !irq)
      else $error("irq still high after flag clear");
   chk_mask_off: assert property ((wr_done && pstrb[0] &&
      ((at_status && !pwdata[4]) || (paddr == pmc_pkg::PMC_OFF_INT_MASK && !pwdata[0])))
      |-> ##[1:2] !irq)
      else $error("irq high with enable clear");
   chk_irq_steady: assert property ((quiet_ff >= 4'h8 && !wr_done && !$past(wr_done) &&
      !$past(wr_done, 2)) |-> $stable(irq))
      else $error("irq moved without tick or write");
   cover property ($rose(irq));
   cover property (pslverr);
   cover property (wr_done && paddr == pmc_pkg::PMC_OFF_COMPARE_LIMIT);
endmodule // pmc_chk
bind pmc_top pmc_chk #(.ADDR_W(ADDR_W)) pmc_chk_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .low_power_osc(low_power_osc), .external_ref_clock(external_ref_clock),
   .internal_ref_clock(internal_ref_clock), .irq(irq));
`default_nettype wire

// *** verilog/pmc_pkg.sv ***
// Purpose: Shared constants, types and divide table for the periodic modulus counter
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Divide table is indexed by clock_source_select[0] and prescale_select
package pmc_pkg;

   localparam int unsigned PMC_ADDR_W = 8;
   localparam int unsigned PMC_DIV_W = 18;

   // Register byte offsets
   localparam logic [7:0] PMC_OFF_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] PMC_OFF_COUNT_VALUE = 8'h04;
   localparam logic [7:0] PMC_OFF_COMPARE_LIMIT = 8'h08;
   localparam logic [7:0] PMC_OFF_INT_STATUS = 8'h0c;
   localparam logic [7:0] PMC_OFF_INT_MASK = 8'h10;

   // Field positions inside status_control, and of the periodic bit in the interrupt status and mask registers
   localparam int unsigned PMC_FLAG_BIT = 7;
   localparam int unsigned PMC_IRQ_EN_BIT = 4;
   localparam int unsigned PMC_INT_PERIODIC_BIT = 0;

   // Values after reset
   localparam logic [1:0] PMC_CLKS_RESET = 2'h0;
   localparam logic [3:0] PMC_PS_RESET = 4'h0;
   localparam logic [7:0] PMC_COUNT_RESET = 8'h00;
   localparam logic [7:0] PMC_LIMIT_RESET = 8'h00;

   // Clock source codes
   localparam logic [1:0] PMC_SRC_LOW_POWER_OSC = 2'h0;
   localparam logic [1:0] PMC_SRC_EXTERNAL_REF = 2'h1;

   localparam int unsigned PMC_SRC_NUM = 3;
   localparam int unsigned PMC_SRC_LPO_IDX = 0;
   localparam int unsigned PMC_SRC_EXT_IDX = 1;
   localparam int unsigned PMC_SRC_INT_IDX = 2;

   // Same layout as the status_control register
   typedef struct packed {
      logic periodic_flag;
      logic [1:0] clock_source_select;
      logic periodic_irq_enable;
      logic [3:0] prescale_select;
   } pmc_ctrl_type;

   typedef enum logic [2:0] {
      PMC_APB_IDLE = 3'b001,
      PMC_APB_WAIT = 3'b010,
      PMC_APB_DONE = 3'b100
   } pmc_apb_state_type;

   // Source edges per prescaler output period; zero means off
   function automatic logic [PMC_DIV_W-1:0] pmc_divide(input logic decimal_src,
                                                       input logic [3:0] ps);
      logic [PMC_DIV_W-1:0] d;
      d = 18'h0;
      if (!decimal_src) begin
         unique case (ps)
            4'h0: d = 18'h0;
            4'h1: d = 18'h8;
            4'h2: d = 18'h20;
            4'h3: d = 18'h40;
            4'h4: d = 18'h80;
            4'h5: d = 18'h100;
            4'h6: d = 18'h200;
            4'h7: d = 18'h400;
            4'h8: d = 18'h1;
            4'h9: d = 18'h2;
            4'ha: d = 18'h4;
            4'hb: d = 18'ha;
            4'hc: d = 18'h10;
            4'hd: d = 18'h64;
            4'he: d = 18'h1f4;
            4'hf: d = 18'h3e8;
         endcase
      end else begin
         unique case (ps)
            4'h0: d = 18'h0;
            4'h1: d = 18'h400;
            4'h2: d = 18'h800;
            4'h3: d = 18'h1000;
            4'h4: d = 18'h2000;
            4'h5: d = 18'h4000;
            4'h6: d = 18'h8000;
            4'h7: d = 18'h10000;
            4'h8: d = 18'h3e8;
            4'h9: d = 18'h7d0;
            4'ha: d = 18'h1388;
            4'hb: d = 18'h2710;
            4'hc: d = 18'h4e20;
            4'hd: d = 18'hc350;
            4'he: d = 18'h186a0;
            4'hf: d = 18'h30d40;
         endcase
      end
      return d;
   endfunction

endpackage

// *** verilog/pmc_prescaler.sv ***
// Purpose: Divides synchronised source-clock edges down to one tick per period
// Assumes: src_edge is a one-cycle pulse on pclk
// Notes: A divide of zero keeps the prescaler off and its count at zero
`timescale 1ns/1ps
`default_nettype none

module pmc_prescaler #(
   parameter int unsigned DIV_W = pmc_pkg::PMC_DIV_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic src_edge,
   input wire logic [DIV_W-1:0] divide,
   input wire logic restart,
   output logic tick
);

   logic [DIV_W-1:0] count_ff;
   logic tick_ff;
   logic running;
   logic at_end;

   assign running = (divide != '0);
   assign at_end = (count_ff >= divide - DIV_W'(1));
   assign tick = tick_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
      end else if (restart || !running) begin
         count_ff <= '0; // RULE_04
      end else if (src_edge) begin
         count_ff <= at_end ? '0 : count_ff + DIV_W'(1); // RULE_07
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= !restart && running && src_edge && at_end;
      end
   end

endmodule // pmc_prescaler

`default_nettype wire

// *** verilog/pmc_top.sv ***
// Purpose: Periodic modulus counter with selectable source, prescaler and APB registers
// Assumes: Source clocks arrive as pins, much slower than pclk (at most pclk/4)
// Notes: All counting is done on pclk from synchronised source edges
// Overview of operation
// (RULE_01) Eight-bit up-counter, eight-bit limit, source selector, binary or decimal prescaler.
// (RULE_02) Reset stops counter at zero, clears limit, prescaler off.
// (RULE_03) Reset selects the low power oscillator as source.
// (RULE_04) Prescale code zero keeps prescaler off; nonzero code starts it.
// (RULE_05) Source code 00 low power, 01 external, 10 or 11 internal.
// (RULE_06) Writing a different source clears prescaler and counter.
// (RULE_07) Divide ratio set by prescale code and source bit zero.
// (RULE_08) Writing a different prescale code clears prescaler and counter.
// (RULE_09) Compare limit accepts every value zero to 0xff.
// (RULE_10) Counter steps once per prescaler period, wraps to zero after limit.
// (RULE_11) Flag sets on the step from limit to zero.
// (RULE_12) Any write of compare limit clears prescaler and counter.
// (RULE_13) Interrupt requested while flag and enable are both set.
// (RULE_14) Writing one to flag clears flag and pending request.
// (RULE_15) Writing zero to flag leaves it unchanged.
// (RULE_16) Limit of zero sets flag on every prescaler tick.
// (RULE_17) Count value is read only; writes do nothing.
// (RULE_18) Source ticks are synchronised to pclk before use.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pmc_top #(
   parameter int unsigned ADDR_W = pmc_pkg::PMC_ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_power_osc,
   input wire logic external_ref_clock,
   input wire logic internal_ref_clock,
   output logic irq
);

   // Register state
   pmc_pkg::pmc_ctrl_type ctrl_ff;
   logic [7:0] count_value_ff; // RULE_01
   logic [7:0] compare_limit_ff; // RULE_01
   logic irq_ff;

   // APB slave state
   pmc_pkg::pmc_apb_state_type apb_state_ff;
   pmc_pkg::pmc_apb_state_type nxt_apb_state;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // Source synchronisers
   logic [pmc_pkg::PMC_SRC_NUM-1:0] src_meta_ff;
   logic [pmc_pkg::PMC_SRC_NUM-1:0] src_sync_ff;
   logic [pmc_pkg::PMC_SRC_NUM-1:0] src_prev_ff;
   logic [pmc_pkg::PMC_SRC_NUM-1:0] src_rise;
   logic src_edge;

   // Decoded access
   logic access;
   logic wr_commit;
   logic sel_status_control;
   logic sel_count_value;
   logic sel_compare_limit;
   logic sel_int_status;
   logic sel_int_mask;
   logic addr_mapped;
   logic [31:0] rd_value;

   // Write effects
   pmc_pkg::pmc_ctrl_type wr_ctrl;
   logic clks_changed;
   logic ps_changed;
   logic restart;
   logic flag_clear;
   logic flag_set;
   logic prescale_tick;
   logic [pmc_pkg::PMC_DIV_W-1:0] divide;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return ((a >> 2) == (ADDR_W'(off) >> 2)) && (a[1:0] == 2'h0);
   endfunction

   // ------------------------------------------------------------------
   // Source selection and synchronisation
   // ------------------------------------------------------------------

   // Three flops per pin; the first is read only by the second, the third keeps the last value for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_meta_ff <= '0;
         src_sync_ff <= '0;
         src_prev_ff <= '0;
      end else begin
         src_meta_ff <= {internal_ref_clock, external_ref_clock, low_power_osc}; // RULE_18
         src_sync_ff <= src_meta_ff; // RULE_18
         src_prev_ff <= src_sync_ff;
      end
   end

   assign src_rise = src_sync_ff & ~src_prev_ff;

   // Selected after synchronisation, so a source switch cannot glitch a clock
   always_comb begin
      unique case (ctrl_ff.clock_source_select)
         pmc_pkg::PMC_SRC_LOW_POWER_OSC:
            src_edge = src_rise[pmc_pkg::PMC_SRC_LPO_IDX]; // RULE_05
         pmc_pkg::PMC_SRC_EXTERNAL_REF:
            src_edge = src_rise[pmc_pkg::PMC_SRC_EXT_IDX]; // RULE_05
         default:
            src_edge = src_rise[pmc_pkg::PMC_SRC_INT_IDX]; // RULE_05
      endcase
   end

   assign divide = pmc_pkg::pmc_divide(ctrl_ff.clock_source_select[0],
                                       ctrl_ff.prescale_select); // RULE_07

   pmc_prescaler #(
      .DIV_W(pmc_pkg::PMC_DIV_W)
   ) u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .src_edge(src_edge),
      .divide(divide),
      .restart(restart),
      .tick(prescale_tick)
   );

   // ------------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // ------------------------------------------------------------------

   assign access = psel && penable;
   assign wr_commit = access && pwrite && pready_ff && !pslverr_ff;

   assign sel_status_control = addr_hit(paddr, pmc_pkg::PMC_OFF_STATUS_CONTROL);
   assign sel_count_value = addr_hit(paddr, pmc_pkg::PMC_OFF_COUNT_VALUE);
   assign sel_compare_limit = addr_hit(paddr, pmc_pkg::PMC_OFF_COMPARE_LIMIT);
   assign sel_int_status = addr_hit(paddr, pmc_pkg::PMC_OFF_INT_STATUS);
   assign sel_int_mask = addr_hit(paddr, pmc_pkg::PMC_OFF_INT_MASK);
   assign addr_mapped = sel_status_control || sel_count_value || sel_compare_limit ||
                        sel_int_status || sel_int_mask;

   always_comb begin
      nxt_apb_state = apb_state_ff;
      unique case (apb_state_ff)
         pmc_pkg::PMC_APB_IDLE: begin
            if (access) begin
               nxt_apb_state = pmc_pkg::PMC_APB_WAIT;
            end
         end
         pmc_pkg::PMC_APB_WAIT: begin
            nxt_apb_state = pmc_pkg::PMC_APB_DONE;
         end
         pmc_pkg::PMC_APB_DONE: begin
            nxt_apb_state = pmc_pkg::PMC_APB_IDLE;
         end
         default: begin
            nxt_apb_state = pmc_pkg::PMC_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_state_ff <= pmc_pkg::PMC_APB_IDLE;
      end else begin
         apb_state_ff <= nxt_apb_state;
      end
   end

   // Ready is high for exactly the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= (apb_state_ff == pmc_pkg::PMC_APB_IDLE) && access;
         pslverr_ff <= (apb_state_ff == pmc_pkg::PMC_APB_IDLE) && access && !addr_mapped;
      end
   end

   always_comb begin
      rd_value = 32'h0;
      if (sel_status_control) begin
         rd_value = {24'h0, ctrl_ff};
      end else if (sel_count_value) begin
         rd_value = {24'h0, count_value_ff};
      end else if (sel_compare_limit) begin
         rd_value = {24'h0, compare_limit_ff};
      end else if (sel_int_status) begin
         rd_value = {31'h0, ctrl_ff.periodic_flag};
      end else if (sel_int_mask) begin
         rd_value = {31'h0, ctrl_ff.periodic_irq_enable};
      end
   end

   // Read data is captured on the same edge that raises ready, so it may lag a tick by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0;
      end else if ((apb_state_ff == pmc_pkg::PMC_APB_IDLE) && access && !pwrite) begin
         prdata_ff <= rd_value;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   // ------------------------------------------------------------------
   // Write effects
   // ------------------------------------------------------------------

   assign wr_ctrl = pmc_pkg::pmc_ctrl_type'(pwdata[7:0]);
   assign clks_changed = wr_commit && sel_status_control && pstrb[0] &&
                         (wr_ctrl.clock_source_select != ctrl_ff.clock_source_select);
   assign ps_changed = wr_commit && sel_status_control && pstrb[0] &&
                       (wr_ctrl.prescale_select != ctrl_ff.prescale_select);
   assign restart = clks_changed || ps_changed || // RULE_06 RULE_08
                    (wr_commit && sel_compare_limit && pstrb[0]); // RULE_12

   // Writing one clears; zero is ignored
   assign flag_clear = wr_commit && pstrb[0] &&
                       ((sel_status_control && pwdata[pmc_pkg::PMC_FLAG_BIT]) ||
                        (sel_int_status && pwdata[pmc_pkg::PMC_INT_PERIODIC_BIT])); // RULE_14 RULE_15

   assign flag_set = prescale_tick && !restart &&
                     (count_value_ff == compare_limit_ff); // RULE_11 RULE_16

   // One process for the whole register, so no field has a second driver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff.clock_source_select <= pmc_pkg::PMC_CLKS_RESET; // RULE_03
         ctrl_ff.prescale_select <= pmc_pkg::PMC_PS_RESET; // RULE_02
         ctrl_ff.periodic_irq_enable <= 1'b0;
         ctrl_ff.periodic_flag <= 1'b0;
      end else begin
         if (wr_commit && sel_status_control && pstrb[0]) begin
            ctrl_ff.clock_source_select <= wr_ctrl.clock_source_select; // RULE_05
            ctrl_ff.prescale_select <= wr_ctrl.prescale_select; // RULE_04
            ctrl_ff.periodic_irq_enable <= wr_ctrl.periodic_irq_enable;
         end else if (wr_commit && sel_int_mask && pstrb[0]) begin
            ctrl_ff.periodic_irq_enable <= pwdata[pmc_pkg::PMC_INT_PERIODIC_BIT];
         end
         // Set beats clear so a tick in the clearing cycle is kept
         if (flag_set) begin
            ctrl_ff.periodic_flag <= 1'b1; // RULE_11
         end else if (flag_clear) begin
            ctrl_ff.periodic_flag <= 1'b0; // RULE_14
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_limit_ff <= pmc_pkg::PMC_LIMIT_RESET; // RULE_02
      end else if (wr_commit && sel_compare_limit && pstrb[0]) begin
         compare_limit_ff <= pwdata[7:0]; // RULE_09
      end
   end

   // ------------------------------------------------------------------
   // Main counter; count_value has no write path
   // ------------------------------------------------------------------

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value_ff <= pmc_pkg::PMC_COUNT_RESET; // RULE_02
      end else if (restart) begin
         count_value_ff <= pmc_pkg::PMC_COUNT_RESET; // RULE_06 RULE_08 RULE_12
      end else if (prescale_tick) begin
         if (count_value_ff == compare_limit_ff) begin
            count_value_ff <= pmc_pkg::PMC_COUNT_RESET; // RULE_10
         end else begin
            count_value_ff <= count_value_ff + 8'h01; // RULE_10
         end
      end
   end // RULE_17

   // ------------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------------

   // Follows the flag one cycle later, so a clear drops it one cycle after the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= ctrl_ff.periodic_flag && ctrl_ff.periodic_irq_enable; // RULE_13
      end
   end

   assign irq = irq_ff;

endmodule // pmc_top

`default_nettype wire
